/* rtl/ptab_table_access.sv */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ptab_defs.svh"
module ptab_table_access #(
    parameter int AW = 21,
    parameter int EXT_BASE = 21'h100000
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic vpp_present,
    input wire logic int_flag_any,
    input wire logic int_flag_high,
    input wire logic int_flag_low,
    output logic [21:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic mem_prog,
    output logic [15:0] mem_wdata,
    output logic ext_wr,
    output logic [7:0] ext_wdata,
    output logic core_sleep,
    output logic core_vector,
    output logic [20:0] core_vector_addr
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers for the pin-level inputs
logic [1:0] vpp_s;
logic [1:0] ia_s;
logic [1:0] ih_s;
logic [1:0] il_s;
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        vpp_s <= 2'h0;
        ia_s <= 2'h0;
        ih_s <= 2'h0;
        il_s <= 2'h0;
    end else begin
        vpp_s <= {vpp_s[0], vpp_present};
        ia_s <= {ia_s[0], int_flag_any};
        ih_s <= {ih_s[0], int_flag_high};
        il_s <= {il_s[0], int_flag_low};
    end
end
wire vpp_ok = vpp_s[1];

////////////////////////////////////////////////////////////////////////////////
// registers
logic [7:0] table_latch;
logic [7:0] table_pointer_upper;
logic [7:0] table_pointer_high;
logic [7:0] table_pointer_low;
logic [7:0] holding; // not visible to software
logic priority_levels_enable;
logic long_write_enable;
logic global_high_enable;
logic global_low_enable;
ptab_pkg::ptab_state_t state;
ptab_pkg::ptab_upd_t op_upd;
logic op_write;
logic end_ext;

wire [21:0] table_pointer = {table_pointer_upper[5:0], table_pointer_high, table_pointer_low};

// only the low 21 bits move, bit 21 is kept
function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic up);
    logic [20:0] low;
    low = up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001;
    return {p[21], low};
endfunction

// address of the access being commanded now: pre-increment moves first
// taken from the command word, not the last operation, so the external check sees this access
wire [21:0] access_ptr = (w_data[1:0] == 2'h3) ? ptr_step(table_pointer, 1'b1) : table_pointer;
// pointer after the access
function automatic logic [21:0] ptr_after(input logic [21:0] a, input ptab_pkg::ptab_upd_t u);
    case (u)
        ptab_pkg::PTAB_UPD_POSTINC: return ptr_step(a, 1'b1);
        ptab_pkg::PTAB_UPD_POSTDEC: return ptr_step(a, 1'b0);
        default: return a;
    endcase
endfunction

// external memory sits above the internal range in user space
wire is_ext = (access_ptr[21] == 1'b0) && (access_ptr[20:0] >= EXT_BASE[20:0]);

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write channel: address and data taken in either order
logic aw_held;
logic w_held;
logic [11:0] aw_addr;
logic [31:0] w_data;
logic [3:0] w_strb;
wire wr_go = aw_held && w_held && !s_axi_bvalid;
wire busy = (state != ptab_pkg::PTAB_IDLE);
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 12'h000;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known(aw_addr) ? 2'h0 : 2'h2;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
    end else begin
        s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
        s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
end

// decode shared by write response and read response
function automatic logic wr_known(input logic [11:0] a);
    case (a)
        `PTAB_RESET_CONTROL_OFF, `PTAB_TABLE_LATCH_OFF, `PTAB_TABLE_POINTER_LOW_OFF,
        `PTAB_TABLE_POINTER_HIGH_OFF, `PTAB_TABLE_POINTER_UPPER_OFF, `PTAB_TABLE_OP_OFF,
        `PTAB_INT_CONTROL_OFF, `PTAB_STATUS_OFF: return 1'b1;
        default: return 1'b0;
    endcase
endfunction

wire wr_en = wr_go && w_strb[0];
wire op_cmd = wr_en && (aw_addr == `PTAB_TABLE_OP_OFF) && !busy;

////////////////////////////////////////////////////////////////////////////////
// control bits; the long-write enable only sets, reset alone clears it
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        priority_levels_enable <= 1'b0;
        long_write_enable <= 1'b0;
        global_high_enable <= 1'b0;
        global_low_enable <= 1'b0;
    end else if (wr_en && aw_addr == `PTAB_RESET_CONTROL_OFF) begin
        priority_levels_enable <= w_data[`PTAB_RC_PRIO_BIT];
        long_write_enable <= long_write_enable | w_data[`PTAB_RC_LWE_BIT];
    end else if (wr_en && aw_addr == `PTAB_INT_CONTROL_OFF) begin
        global_high_enable <= w_data[`PTAB_IC_GHIGH_BIT];
        global_low_enable <= w_data[`PTAB_IC_GLOW_BIT];
    end
end

////////////////////////////////////////////////////////////////////////////////
// pointer and latch: software writes, or the table operation
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        table_pointer_upper <= 8'h00;
        table_pointer_high <= 8'h00;
        table_pointer_low <= 8'h00;
    end else if (op_cmd) begin
        {table_pointer_upper[5:0], table_pointer_high, table_pointer_low} <= 22'h000000;
        table_pointer_upper[7:6] <= 2'h0;
        {table_pointer_upper[5:0], table_pointer_high, table_pointer_low} <=
            ptr_after(w_data[1:0] == 2'h3 ? ptr_step(table_pointer, 1'b1) : table_pointer,
                ptab_pkg::ptab_upd_t'(w_data[1:0]));
    end else if (wr_en && !busy) begin
        if (aw_addr == `PTAB_TABLE_POINTER_LOW_OFF) table_pointer_low <= w_data[7:0];
        if (aw_addr == `PTAB_TABLE_POINTER_HIGH_OFF) table_pointer_high <= w_data[7:0];
        if (aw_addr == `PTAB_TABLE_POINTER_UPPER_OFF) table_pointer_upper <= {2'h0, w_data[5:0]};
    end
end

always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        table_latch <= 8'h00;
    end else if (state == ptab_pkg::PTAB_READ) begin
        table_latch <= mem_rdata;
    end else if (wr_en && !busy && aw_addr == `PTAB_TABLE_LATCH_OFF) begin
        table_latch <= w_data[7:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// operation sequencer; the access address is frozen at the command
logic [21:0] op_addr;
wire prog_end_irq = ia_s[1]; // only enabled flagged sources reach here
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        state <= ptab_pkg::PTAB_IDLE;
        op_upd <= ptab_pkg::PTAB_UPD_NONE;
        op_write <= 1'b0;
        op_addr <= 22'h000000;
        holding <= 8'h00;
        end_ext <= 1'b0;
    end else begin
        case (state)
            ptab_pkg::PTAB_IDLE: begin
                if (op_cmd) begin
                    op_upd <= ptab_pkg::ptab_upd_t'(w_data[1:0]);
                    op_write <= w_data[`PTAB_OP_WRITE_BIT];
                    op_addr <= (w_data[1:0] == 2'h3) ? ptr_step(table_pointer, 1'b1) : table_pointer;
                    if (!w_data[`PTAB_OP_WRITE_BIT]) begin
                        state <= ptab_pkg::PTAB_READ;
                    end else begin
                        state <= ptab_pkg::PTAB_DONE;
                    end
                end
            end
            ptab_pkg::PTAB_READ: state <= ptab_pkg::PTAB_IDLE;
            ptab_pkg::PTAB_DONE: begin
                // write decision one cycle after command
                if (end_ext) begin
                    state <= ptab_pkg::PTAB_IDLE; // external write ignores enable
                end else if (!op_addr[0]) begin
                    holding <= table_latch; // short write only
                    state <= ptab_pkg::PTAB_IDLE;
                end else if (vpp_ok && long_write_enable) begin
                    state <= ptab_pkg::PTAB_PROG;
                end else begin
                    state <= ptab_pkg::PTAB_IDLE; // memory untouched
                end
            end
            ptab_pkg::PTAB_PROG: begin
                if (prog_end_irq) state <= ptab_pkg::PTAB_IDLE; // flag left to software
            end
            default: state <= ptab_pkg::PTAB_IDLE;
        endcase
        if (op_cmd) end_ext <= is_ext;
    end
end

////////////////////////////////////////////////////////////////////////////////
// memory strobes and core control outputs
wire [21:0] blk = {op_addr[21:1], 1'b0};
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        mem_addr <= 22'h000000;
        mem_rd <= 1'b0;
        mem_prog <= 1'b0;
        mem_wdata <= 16'h0000;
        ext_wr <= 1'b0;
        ext_wdata <= 8'h00;
        core_sleep <= 1'b0;
    end else begin
        mem_rd <= op_cmd && !w_data[`PTAB_OP_WRITE_BIT];
        if (op_cmd) mem_addr <= (w_data[1:0] == 2'h3) ? ptr_step(table_pointer, 1'b1) : table_pointer;
        else if (state == ptab_pkg::PTAB_DONE) mem_addr <= blk;
        ext_wr <= (state == ptab_pkg::PTAB_DONE) && end_ext;
        ext_wdata <= table_latch;
        // programming held for the whole sleep
        mem_prog <= (state == ptab_pkg::PTAB_DONE && !end_ext && op_addr[0] && vpp_ok && long_write_enable) ||
            (state == ptab_pkg::PTAB_PROG && !prog_end_irq);
        if (state == ptab_pkg::PTAB_DONE) mem_wdata <= {table_latch, holding};
        core_sleep <= (state == ptab_pkg::PTAB_DONE && !end_ext && op_addr[0] && vpp_ok && long_write_enable) ||
            (state == ptab_pkg::PTAB_PROG && !prog_end_irq);
    end
end

// vectoring choice when the interrupt ends programming
wire hi_go = priority_levels_enable ? (ih_s[1] && global_high_enable) : global_high_enable;
wire lo_go = priority_levels_enable && il_s[1] && global_low_enable;
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        core_vector <= 1'b0;
        core_vector_addr <= 21'h000000;
    end else begin
        core_vector <= 1'b0;
        if (state == ptab_pkg::PTAB_PROG && prog_end_irq) begin
            // global enable clear: continue with next instruction
            core_vector <= hi_go || lo_go;
            core_vector_addr <= hi_go ? `PTAB_VEC_HIGH : `PTAB_VEC_LOW;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// read channel, one cycle after the address is taken
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h0;
    end else begin
        s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= wr_known(s_axi_araddr) ? 2'h0 : 2'h2;
            case (s_axi_araddr)
                `PTAB_RESET_CONTROL_OFF: s_axi_rdata <= {24'h000000, priority_levels_enable,
                    long_write_enable, 6'h1C};
                `PTAB_TABLE_LATCH_OFF: s_axi_rdata <= {24'h000000, table_latch};
                `PTAB_TABLE_POINTER_LOW_OFF: s_axi_rdata <= {24'h000000, table_pointer_low};
                `PTAB_TABLE_POINTER_HIGH_OFF: s_axi_rdata <= {24'h000000, table_pointer_high};
                `PTAB_TABLE_POINTER_UPPER_OFF: s_axi_rdata <= {24'h000000, table_pointer_upper};
                `PTAB_INT_CONTROL_OFF: s_axi_rdata <= {24'h000000, global_high_enable, global_low_enable, 6'h00};
                `PTAB_STATUS_OFF: s_axi_rdata <= {28'h0000000, state};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule

/* rtl/ptab_defs.svh */
`ifndef PTAB_DEFS_SVH
`define PTAB_DEFS_SVH

// register byte offsets on the axi4-lite slave
`define PTAB_RESET_CONTROL_OFF 12'h008
`define PTAB_TABLE_LATCH_OFF 12'h010
`define PTAB_TABLE_POINTER_LOW_OFF 12'h014
`define PTAB_TABLE_POINTER_HIGH_OFF 12'h018
`define PTAB_TABLE_POINTER_UPPER_OFF 12'h01C
`define PTAB_TABLE_OP_OFF 12'h020
`define PTAB_INT_CONTROL_OFF 12'h024
`define PTAB_STATUS_OFF 12'h028

// reset_control field positions and reset value
`define PTAB_RC_PRIO_BIT 7
`define PTAB_RC_LWE_BIT 6
`define PTAB_RC_RESET 8'h1C

// interrupt_control field positions
`define PTAB_IC_GHIGH_BIT 7
`define PTAB_IC_GLOW_BIT 6

// table_op command fields
`define PTAB_OP_WRITE_BIT 2

// program memory vectors
`define PTAB_VEC_HIGH 21'h000008
`define PTAB_VEC_LOW 21'h000018

`endif

/* rtl/ptab_pkg.sv */
package ptab_pkg;
    // pointer update chosen by the instruction variant
    typedef enum logic [1:0] {
        PTAB_UPD_NONE = 2'h0,
        PTAB_UPD_POSTINC = 2'h1,
        PTAB_UPD_POSTDEC = 2'h2,
        PTAB_UPD_PREINC = 2'h3
    } ptab_upd_t;

    typedef enum logic [3:0] {
        PTAB_IDLE = 4'h1,
        PTAB_READ = 4'h2,
        PTAB_PROG = 4'h4,
        PTAB_DONE = 4'h8
    } ptab_state_t;
endpackage

/* sim/ptab_monitor.sv */
`timescale 1ns/1ps
`include "ptab_defs.svh"
module ptab_monitor (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic vpp_present,
    input wire logic int_flag_any,
    input wire logic [21:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_prog,
    input wire logic [15:0] mem_wdata,
    input wire logic ext_wr,
    input wire logic core_sleep,
    input wire logic core_vector,
    input wire logic [20:0] core_vector_addr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // program port: one fetch strobe, a steady block while programming
    a_read_pulse: assert property (mem_rd |=> !mem_rd)
        else $error("memory read strobe longer than one cycle");
    a_sleep_prog: assert property (mem_prog |-> core_sleep)
        else $error("core not halted during long write");
    a_block_even: assert property (mem_prog |-> !mem_addr[0])
        else $error("block address not even");
    // the voltage pin passes two flip-flops before the decision edge
    a_prog_vpp: assert property ($rose(mem_prog) |-> $past(vpp_present, 2))
        else $error("long write started without programming voltage");
    a_prog_steady: assert property (mem_prog && $past(mem_prog) |-> $stable(mem_wdata) && $stable(mem_addr))
        else $error("block data or address moved while programming");
    // the flag passes a synchroniser, so only a long quiet spell must keep the write going
    a_prog_holds: assert property (mem_prog && !int_flag_any && !$past(int_flag_any)
        && !$past(int_flag_any, 2) && !$past(int_flag_any, 3) |=> mem_prog)
        else $error("long write ended with no flagged source");
    a_prog_ends: assert property (mem_prog && int_flag_any |-> ##[1:8] !mem_prog)
        else $error("long write not ended by flagged source");
    a_vec_addr: assert property (core_vector |-> core_vector_addr inside {`PTAB_VEC_HIGH, `PTAB_VEC_LOW})
        else $error("vector address is neither level vector");
    a_ext_plain: assert property (ext_wr |-> !mem_prog && !core_sleep)
        else $error("external write programmed internal memory");
    c_read: cover property (mem_rd);
    c_prog: cover property ($rose(mem_prog));
    c_vec: cover property (core_vector);
    c_ext: cover property (ext_wr);
endmodule

bind ptab_table_access ptab_monitor i_ptab_monitor (.ref_clk, .nrst, .vpp_present, .int_flag_any, .mem_addr,
    .mem_rd, .mem_prog, .mem_wdata, .ext_wr, .core_sleep, .core_vector, .core_vector_addr);

/* sim/ptab_mem_model.sv */
`timescale 1ns/1ps
module ptab_mem_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [21:0] mem_addr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata,
    input wire logic mem_prog,
    input wire logic [15:0] mem_wdata
);
    logic [7:0] mem [0:255];
    logic rd_d;
    logic prog_d;
    logic [7:0] idx;
    // id space kept apart from main space by folding bit 21 into the index
    assign idx = {mem_addr[21], mem_addr[6:0]};
    // data only valid in strobe cycle and the next; inverted otherwise so stale bytes show
    assign mem_rdata = (mem_rd || rd_d) ? mem[idx] : ~mem[idx];
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) rd_d <= 1'b0;
        else rd_d <= mem_rd;
    end
    // block programmed at the start of the long write: latch high, holding low
    always @(posedge ref_clk) begin
        prog_d <= mem_prog;
        if (mem_prog && !prog_d) begin
            mem[idx] <= mem_wdata[7:0];
            mem[idx | 8'h01] <= mem_wdata[15:8];
        end
    end
    initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'hA5;
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
`include "ptab_defs.svh"
module tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic vpp_present = 0, int_flag_any = 0, int_flag_high = 0, int_flag_low = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic mem_rd, mem_prog, ext_wr, core_sleep, core_vector;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    logic [21:0] mem_addr;
    logic [7:0] mem_rdata, ext_wdata, ext_seen;
    logic [15:0] mem_wdata;
    logic [20:0] core_vector_addr, vec_seen;
    int n_fail = 0, checks_done = 0, n_vec = 0, n_ext = 0;

    always #12.5 ref_clk = ~ref_clk;
    ptab_table_access i_ptab_table_access (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .vpp_present, .int_flag_any, .int_flag_high, .int_flag_low, .mem_addr, .mem_rd, .mem_rdata, .mem_prog,
        .mem_wdata, .ext_wr, .ext_wdata, .core_sleep, .core_vector, .core_vector_addr);
    ptab_mem_model i_ptab_mem_model (.ref_clk, .nrst, .mem_addr, .mem_rd, .mem_rdata, .mem_prog, .mem_wdata);

    // pulses are one cycle wide, so they are counted here rather than polled
    always @(posedge ref_clk) begin
        if (core_vector === 1'b1) begin
            n_vec <= n_vec + 1;
            vec_seen <= core_vector_addr;
        end
        if (ext_wr === 1'b1) begin
            n_ext <= n_ext + 1;
            ext_seen <= ext_wdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // master offers address and data together and drops each once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            k++;
        end while (s_axi_bvalid !== 1'b1 && k < 100);
        if (s_axi_bvalid !== 1'b1) n_fail++;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [11:0] a);
        int k;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            k++;
        end while (s_axi_rvalid !== 1'b1 && k < 100);
        if (s_axi_rvalid !== 1'b1) n_fail++;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input string w, input logic [11:0] a, input logic [31:0] e);
        rdr(a);
        chk(w, e, rd);
    endtask
    task automatic idle;
        for (int i = 0; i < 60; i++) begin
            rdr(`PTAB_STATUS_OFF);
            if (rd === 32'h1) break;
        end
        chk("status", 32'h1, rd);
    endtask
    task automatic setp(input logic [21:0] p);
        wr(`PTAB_TABLE_POINTER_LOW_OFF, {24'h0, p[7:0]});
        wr(`PTAB_TABLE_POINTER_HIGH_OFF, {24'h0, p[15:8]});
        wr(`PTAB_TABLE_POINTER_UPPER_OFF, {26'h0, p[21:16]});
    endtask
    task automatic getp(output logic [21:0] p);
        rdr(`PTAB_TABLE_POINTER_LOW_OFF);
        p[7:0] = rd[7:0];
        rdr(`PTAB_TABLE_POINTER_HIGH_OFF);
        p[15:8] = rd[7:0];
        rdr(`PTAB_TABLE_POINTER_UPPER_OFF);
        p[21:16] = rd[5:0];
    endtask
    task automatic op(input logic [2:0] x);
        wr(`PTAB_TABLE_OP_OFF, {29'h0, x});
    endtask
    task automatic wl(input logic [7:0] d);
        wr(`PTAB_TABLE_LATCH_OFF, {24'h0, d});
    endtask
    function automatic logic [7:0] mb(input logic [21:0] a);
        return {a[21], a[6:0]} ^ 8'hA5;
    endfunction
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [21:0] p, a, n, q, e;
        logic [7:0] lo, hi;
        logic [1:0] m;
        int v0;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rchk("reset_control", `PTAB_RESET_CONTROL_OFF, 32'h1C);
        rchk("unmapped", 12'h100, 32'h0);
        chk("unmapped resp", 32'h2, rs);
        wr(12'h100, 32'h0);
        chk("unmapped wresp", 32'h2, rs);
        wl(8'h00);
        chk("latch wresp", 32'h0, rs);
        wl(8'hFF);
        rchk("table_latch", `PTAB_TABLE_LATCH_OFF, 32'hFF);
        // reads around the 21-bit wrap, odd addresses, all four updates
        for (int j = 0; j < 8; j++) begin
            p = j[2] ? 22'h200000 : 22'h3FFFFF;
            m = j[1:0];
            a = (m == 2'd3) ? {p[21], p[20:0] + 21'h1} : p;
            n = (m == 2'd0) ? p : (m == 2'd2) ? {p[21], p[20:0] - 21'h1} : {p[21], p[20:0] + 21'h1};
            setp(p);
            op({1'b0, m});
            idle;
            rchk("latch after read", `PTAB_TABLE_LATCH_OFF, {24'h0, mb(a)});
            getp(q);
            chk("pointer", {10'h0, n}, {10'h0, q});
        end
        // pair with voltage but enable clear must leave memory alone
        vpp_present <= 1'b1;
        setp(22'h000020);
        wl(8'h3C);
        op(3'h5);
        idle;
        wl(8'hC3);
        op(3'h4);
        idle;
        setp(22'h000020);
        op(3'h1);
        idle;
        rchk("unprogrammed even", `PTAB_TABLE_LATCH_OFF, {24'h0, mb(22'h20)});
        op(3'h0);
        idle;
        rchk("unprogrammed odd", `PTAB_TABLE_LATCH_OFF, {24'h0, mb(22'h21)});
        wr(`PTAB_RESET_CONTROL_OFF, 32'hC0);
        wr(`PTAB_RESET_CONTROL_OFF, 32'h80);
        rchk("enable sticks", `PTAB_RESET_CONTROL_OFF, 32'hDC);
        // high vector, plain continue, low vector
        for (int c = 0; c < 3; c++) begin
            e = 22'h000040 + 22'(2 * c);
            lo = {4'h5, 4'(c)};
            hi = {4'hA, 4'(c)};
            wr(`PTAB_INT_CONTROL_OFF, (c == 0) ? 32'h80 : (c == 1) ? 32'h0 : 32'h40);
            int_flag_high <= (c != 2);
            int_flag_low <= (c == 2);
            setp(e);
            wl(lo);
            op(3'h5);
            idle;
            wl(hi);
            op(3'h4);
            for (int i = 0; i < 20 && mem_prog !== 1'b1; i++) @(posedge ref_clk);
            chk("core_sleep", 32'h1, {31'h0, core_sleep});
            chk("block data", {16'h0, hi, lo}, {16'h0, mem_wdata});
            chk("block addr", {10'h0, e}, {10'h0, mem_addr});
            v0 = n_vec;
            repeat (30) @(posedge ref_clk);
            chk("still programming", 32'h1, {31'h0, mem_prog});
            int_flag_any <= 1'b1;
            repeat (12) @(posedge ref_clk);
            chk("write ended", 32'h0, {31'h0, mem_prog});
            chk("vectors", v0 + (c != 1), n_vec);
            if (c != 1) chk("vector", {11'h0, (c == 0) ? `PTAB_VEC_HIGH : `PTAB_VEC_LOW}, {11'h0, vec_seen});
            int_flag_any <= 1'b0;
            vpp_present <= 1'b1;
            idle;
            setp(e);
            op(3'h1);
            idle;
            rchk("programmed low", `PTAB_TABLE_LATCH_OFF, {24'h0, lo});
            op(3'h0);
            idle;
            rchk("programmed high", `PTAB_TABLE_LATCH_OFF, {24'h0, hi});
        end
        // external space ignores the enable and just writes the byte
        setp(22'h100004);
        wl(8'h5A);
        v0 = n_ext;
        op(3'h4);
        idle;
        chk("ext writes", v0 + 1, n_ext);
        chk("ext data", 32'h5A, {24'h0, ext_seen});
        nrst <= 1'b0;
        @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rchk("reset clears enable", `PTAB_RESET_CONTROL_OFF, 32'h1C);
        wrap_up;
    end
    // watchdog at 40000 cycles, well beyond the several hundred cycles the sequence needs
    initial begin
        #1000000;
        n_fail++;
        wrap_up;
    end
endmodule
